// *** rtl/pacg_params.svh ***
`ifndef PACG_PARAMS_SVH
`define PACG_PARAMS_SVH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define PACG_IDX_PORT_A_DATA   9'h000
`define PACG_IDX_RSVD_LOW      9'h001
`define PACG_IDX_PORT_A_DIR    9'h002
`define PACG_IDX_RSVD_HIGH     9'h003
`define PACG_IDX_PORT_C_DATA   9'h004
`define PACG_IDX_PORT_C_DIR    9'h006

// ****************************************************************
// reset values
// ****************************************************************
`define PACG_RST_PORT_A_DATA   6'h00
`define PACG_RST_PORT_A_DIR    6'h00
`define PACG_RST_PORT_C_DATA   2'h0
`define PACG_RST_PORT_C_DIR    2'h0
`define PACG_RST_READDATA      32'h0000_0000

// ****************************************************************
// field positions of shared pins
// ****************************************************************
`define PACG_SPI_MISO_BIT      0
`define PACG_SPI_MOSI_BIT      1
`define PACG_SPI_SCK_BIT       2
`define PACG_SPI_SS_BIT        3
`define PACG_LINK_CLK_BIT      0
`define PACG_LINK_INT_BIT      1
`define PACG_SYNC_LINK_INT     7

`endif

// *** rtl/pacg_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// two-flop synchroniser for all port pins
// ****************************************************************
module pacg_pin_sync (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  pacg_sync_if.syncer sync
);

  logic [7:0] meta_q;
  logic [7:0] meta_d;
  logic [7:0] level_q;
  logic [7:0] level_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d  = sync.raw;
    level_d = meta_q;
  end

  // stage registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q  <= 8'h00;
      level_q <= 8'h00;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
    end
  end

  assign sync.level = level_q;

endmodule : pacg_pin_sync

`default_nettype wire

// *** rtl/pacg_pkg.sv ***
// ****************************************************************
// shared types
// ****************************************************************
package pacg_pkg;

  typedef enum logic {
    PACG_BUS_IDLE,
    PACG_BUS_ACK
  } pacg_bus_e;

  typedef logic [5:0] pacg_port_a_t;
  typedef logic [1:0] pacg_port_c_t;
  typedef logic [8:0] pacg_index_t;

endpackage : pacg_pkg

// *** rtl/pacg_port_mux.sv ***
// Function
// R1: a data bit reads back the stored value when its direction bit is 1, else the synced pin.
// R2: port A pins 2, 1 and 0 carry SPI clock, master-out and master-in when SPI owns them.
// R3: port C pin 1 carries the die link interrupt in and pin 0 the die link clock out.
// R4: a pin not taken by its peripheral is plain GPIO steered by its data and direction bits.
// R5: port A direction bits 5 to 0 drive the pin when 1 and leave it high impedance when 0.
// R6: while SPI owns a port A pin the SPI sets its direction and the stored bits stay as they are.
// R7: the reserved words at indices 1 and 3 read zero and ignore writes.
// R8: the port A direction register is readable and writable any time and resets to zero.
// R9: the port C data register is readable and writable any time in every mode.
// R10: port A pin 3 carries SPI slave select when SPI owns it, else it is GPIO.
// R11: bits 7 and 6 of port A data and direction read zero and ignore writes.
//
// The Avalon-MM register port was left to the implementer.
`include "pacg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pacg_port_mux (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [10:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  spi_pin_own,
  input  wire logic [3:0]  spi_pin_out,
  input  wire logic [3:0]  spi_pin_oe,
  output logic      [3:0]  spi_pin_in,
  input  wire logic        die_link_enable,
  input  wire logic        die_link_clock_src,
  output logic             die_link_interrupt_in,
  input  wire logic [5:0]  pa_pin_in,
  output logic      [5:0]  pa_pin_out,
  output logic      [5:0]  pa_pin_oe,
  input  wire logic [1:0]  pc_pin_in,
  output logic      [1:0]  pc_pin_out,
  output logic      [1:0]  pc_pin_oe
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  pacg_pkg::pacg_bus_e     bus_q;
  pacg_pkg::pacg_bus_e     bus_d;
  logic                    wait_q;
  logic                    wait_d;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  pacg_pkg::pacg_port_a_t  port_a_data_bits_q;
  pacg_pkg::pacg_port_a_t  port_a_data_bits_d;
  pacg_pkg::pacg_port_a_t  port_a_direction_bits_q;
  pacg_pkg::pacg_port_a_t  port_a_direction_bits_d;
  pacg_pkg::pacg_port_c_t  port_c_data_bits_q;
  pacg_pkg::pacg_port_c_t  port_c_data_bits_d;
  pacg_pkg::pacg_port_c_t  port_c_direction_q;
  pacg_pkg::pacg_port_c_t  port_c_direction_d;
  pacg_pkg::pacg_port_a_t  pa_out_q;
  pacg_pkg::pacg_port_a_t  pa_out_d;
  pacg_pkg::pacg_port_a_t  pa_oe_q;
  pacg_pkg::pacg_port_a_t  pa_oe_d;
  pacg_pkg::pacg_port_c_t  pc_out_q;
  pacg_pkg::pacg_port_c_t  pc_out_d;
  pacg_pkg::pacg_port_c_t  pc_oe_q;
  pacg_pkg::pacg_port_c_t  pc_oe_d;
  pacg_pkg::pacg_index_t   index;
  logic [7:0]              read_value;
  pacg_pkg::pacg_port_a_t  pa_level;
  pacg_pkg::pacg_port_c_t  pc_level;

  pacg_sync_if sync_bus ();

  // every assertion below runs on the system clock and sleeps in reset, except a_dir_reset_zero, which stays live in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  assign sync_bus.raw = {pc_pin_in, pa_pin_in};

  pacg_pin_sync pacg_pin_sync_inst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .sync    (sync_bus.syncer)
  );

  assign pa_level = sync_bus.level[5:0];
  assign pc_level = sync_bus.level[7:6];

  // ****************************************************************
  // read view of a data register
  // ****************************************************************
  function automatic logic [7:0] pin_view(
    input logic [7:0] dir,
    input logic [7:0] store,
    input logic [7:0] pin
  );
    return (dir & store) | (~dir & pin);  // see R1
  endfunction : pin_view

  // ****************************************************************
  // register read decode
  // ****************************************************************
  assign index = avs_address[10:2];

  // select the byte a read returns
  always_comb begin
    if (index == `PACG_IDX_PORT_A_DATA) begin
      read_value = pin_view({2'h0, port_a_direction_bits_q},
                            {2'h0, port_a_data_bits_q},
                            {2'h0, pa_level});  // see R1 see R11
    end else if (index == `PACG_IDX_PORT_A_DIR) begin
      read_value = {2'h0, port_a_direction_bits_q};  // see R8 see R11
    end else if (index == `PACG_IDX_PORT_C_DATA) begin
      read_value = pin_view({6'h00, port_c_direction_q},
                            {6'h00, port_c_data_bits_q},
                            {6'h00, pc_level});  // see R1 see R9
    end else if (index == `PACG_IDX_PORT_C_DIR) begin
      read_value = {6'h00, port_c_direction_q};
    end else begin
      read_value = 8'h00;  // reserved and unmapped, see R7
    end
  end

  // ****************************************************************
  // bus slave and register file
  // ****************************************************************
  // one wait cycle, then the answer; writes land at the answer edge
  always_comb begin
    bus_d                   = bus_q;
    wait_d                  = 1'b1;
    rdata_d                 = rdata_q;
    port_a_data_bits_d      = port_a_data_bits_q;
    port_a_direction_bits_d = port_a_direction_bits_q;
    port_c_data_bits_d      = port_c_data_bits_q;
    port_c_direction_d      = port_c_direction_q;
    case (bus_q)
      pacg_pkg::PACG_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d   = pacg_pkg::PACG_BUS_ACK;
          wait_d  = 1'b0;
          rdata_d = {24'h000000, read_value};
        end
      end
      pacg_pkg::PACG_BUS_ACK: begin
        bus_d = pacg_pkg::PACG_BUS_IDLE;
        if (avs_write && avs_byteenable[0]) begin
          if (index == `PACG_IDX_PORT_A_DATA) begin
            port_a_data_bits_d = avs_writedata[5:0];  // see R11
          end else if (index == `PACG_IDX_PORT_A_DIR) begin
            port_a_direction_bits_d = avs_writedata[5:0];  // see R8 see R11
          end else if (index == `PACG_IDX_PORT_C_DATA) begin
            port_c_data_bits_d = avs_writedata[1:0];  // see R9
          end else if (index == `PACG_IDX_PORT_C_DIR) begin
            port_c_direction_d = avs_writedata[1:0];
          end
        end
      end
      default: begin
        bus_d = pacg_pkg::PACG_BUS_IDLE;
      end
    endcase
  end

  // bus and register state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_q                   <= pacg_pkg::PACG_BUS_IDLE;
      wait_q                  <= 1'b1;
      rdata_q                 <= `PACG_RST_READDATA;
      port_a_data_bits_q      <= `PACG_RST_PORT_A_DATA;
      port_a_direction_bits_q <= `PACG_RST_PORT_A_DIR;  // see R8
      port_c_data_bits_q      <= `PACG_RST_PORT_C_DATA;
      port_c_direction_q      <= `PACG_RST_PORT_C_DIR;
    end else begin
      bus_q                   <= bus_d;
      wait_q                  <= wait_d;
      rdata_q                 <= rdata_d;
      port_a_data_bits_q      <= port_a_data_bits_d;
      port_a_direction_bits_q <= port_a_direction_bits_d;
      port_c_data_bits_q      <= port_c_data_bits_d;
      port_c_direction_q      <= port_c_direction_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // ****************************************************************
  // pin drive selection
  // ****************************************************************
  // spi owns pins 3..0 bit by bit; stored direction is only bypassed
  always_comb begin
    pa_oe_d  = port_a_direction_bits_q;  // see R4 see R5
    pa_out_d = port_a_data_bits_q;       // see R4
    for (int i = 0; i < 4; i++) begin
      if (spi_pin_own[i]) begin
        pa_oe_d[i]  = spi_pin_oe[i];   // see R2 see R6 see R10
        pa_out_d[i] = spi_pin_out[i];  // see R2 see R10
      end
    end
    if (die_link_enable) begin
      pc_oe_d  = 2'b01;  // clock out driven, interrupt pin listens, see R3
      pc_out_d = {port_c_data_bits_q[`PACG_LINK_INT_BIT], die_link_clock_src};  // see R3
    end else begin
      pc_oe_d  = port_c_direction_q;  // see R4
      pc_out_d = port_c_data_bits_q;  // see R4
    end
  end

  // registered pin outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pa_out_q <= 6'h00;
      pa_oe_q  <= 6'h00;
      pc_out_q <= 2'h0;
      pc_oe_q  <= 2'h0;
    end else begin
      pa_out_q <= pa_out_d;
      pa_oe_q  <= pa_oe_d;
      pc_out_q <= pc_out_d;
      pc_oe_q  <= pc_oe_d;
    end
  end

  assign pa_pin_out = pa_out_q;
  assign pa_pin_oe  = pa_oe_q;
  assign pc_pin_out = pc_out_q;
  assign pc_pin_oe  = pc_oe_q;

  // peripheral inputs come straight from the synchroniser flops
  assign spi_pin_in            = pa_level[3:0];  // see R2 see R10
  assign die_link_interrupt_in = sync_bus.level[`PACG_SYNC_LINK_INT];  // see R3

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_request;
    (avs_read || avs_write) && bus_q == pacg_pkg::PACG_BUS_IDLE;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_slave_answer_timing : assert property (s_request |=> s_answer)
    else $error("slave did not answer after one wait cycle");

  a_dir_reset_zero : assert property (  // see R8
    @(posedge clk_sys) disable iff (1'b0)
    reset |=> port_a_direction_bits_q == 6'h00)
    else $error("port a direction not zero after reset");

  a_gpio_read_view : assert property (  // see R1
    (!avs_waitrequest && avs_read && index == `PACG_IDX_PORT_A_DATA)
    |-> avs_readdata[5:0] == $past((port_a_direction_bits_q & port_a_data_bits_q)
                                   | (~port_a_direction_bits_q & pa_level)))
    else $error("port a read does not follow direction bits");

  a_rsvd_read_zero : assert property (  // see R7
    (!avs_waitrequest && avs_read &&
     (index == `PACG_IDX_RSVD_LOW || index == `PACG_IDX_RSVD_HIGH))
    |-> avs_readdata == 32'h0000_0000)
    else $error("reserved word read non zero");

  a_rsvd_write_none : assert property (  // see R7
    (!avs_waitrequest && avs_write &&
     (index == `PACG_IDX_RSVD_LOW || index == `PACG_IDX_RSVD_HIGH))
    |=> $stable(port_a_direction_bits_q) && $stable(port_a_data_bits_q)
        && $stable(port_c_data_bits_q))
    else $error("reserved write changed a register");

  a_upper_bits_zero : assert property (  // see R11
    (!avs_waitrequest && avs_read &&
     (index == `PACG_IDX_PORT_A_DATA || index == `PACG_IDX_PORT_A_DIR))
    |-> avs_readdata[7:6] == 2'h0)
    else $error("port a upper bits read non zero");

  a_portc_write_lands : assert property (  // see R9
    (!avs_waitrequest && avs_write && avs_byteenable[0] &&
     index == `PACG_IDX_PORT_C_DATA)
    |=> port_c_data_bits_q == $past(avs_writedata[1:0]))
    else $error("port c data write lost");

  a_spi_pins_drive : assert property (  // see R2
    spi_pin_own[`PACG_SPI_SCK_BIT]
    |=> pa_pin_oe[`PACG_SPI_SCK_BIT] == $past(spi_pin_oe[`PACG_SPI_SCK_BIT])
        && pa_pin_out[`PACG_SPI_SCK_BIT] == $past(spi_pin_out[`PACG_SPI_SCK_BIT]))
    else $error("spi clock pin not driven by spi");

  a_spi_ss_drive : assert property (  // see R10
    !spi_pin_own[`PACG_SPI_SS_BIT]
    |=> pa_pin_oe[`PACG_SPI_SS_BIT] == $past(port_a_direction_bits_q[`PACG_SPI_SS_BIT]))
    else $error("free select pin not steered by direction bit");

  a_gpio_oe_upper : assert property (  // see R4 see R5
    1'b1 |=> pa_pin_oe[5:4] == $past(port_a_direction_bits_q[5:4])
             && pa_pin_out[5:4] == $past(port_a_data_bits_q[5:4]))
    else $error("gpio pins 5 and 4 not steered by registers");

  a_dir_hold_spi : assert property (  // see R6
    (spi_pin_own != 4'h0 && !(avs_write && !avs_waitrequest))
    |=> $stable(port_a_direction_bits_q))
    else $error("direction bits changed without a write");

  a_link_pins_drive : assert property (  // see R3
    die_link_enable |=> pc_pin_oe == 2'b01
                        && pc_pin_out[`PACG_LINK_CLK_BIT] == $past(die_link_clock_src))
    else $error("die link pins not driven as link");

endmodule : pacg_port_mux

`default_nettype wire

// *** rtl/pacg_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// raw pin levels in, synchronised levels out
// ****************************************************************
interface pacg_sync_if;
  logic [7:0] raw;    // {port c, port a} as seen at the pins
  logic [7:0] level;  // same after two flops

  modport owner  (output raw, input level);
  modport syncer (input raw, output level);
endinterface : pacg_sync_if

`default_nettype wire

// *** test/pacg_periph_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// stand-in for the spi and die link peripherals on shared pins
// ****************************************************************
module pacg_periph_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [3:0] spi_own_req,
  input  wire logic [3:0] spi_out_req,
  input  wire logic [3:0] spi_oe_req,
  input  wire logic       link_en_req,
  input  wire logic       link_clk_req,
  output logic      [3:0] spi_pin_own,
  output logic      [3:0] spi_pin_out,
  output logic      [3:0] spi_pin_oe,
  output logic            die_link_enable,
  output logic            die_link_clock_src
);
  // outputs move only just after a clock edge, as real peripheral logic would
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      spi_pin_own        <= 4'h0;
      spi_pin_out        <= 4'h0;
      spi_pin_oe         <= 4'h0;
      die_link_enable    <= 1'b0;
      die_link_clock_src <= 1'b0;
    end else begin
      spi_pin_own        <= spi_own_req;
      spi_pin_out        <= spi_out_req & spi_own_req;  // unowned pins carry nothing
      spi_pin_oe         <= spi_oe_req & spi_own_req;
      die_link_enable    <= link_en_req;
      die_link_clock_src <= link_en_req & link_clk_req; // clock stands low when idle
    end
  end
endmodule : pacg_periph_model

`default_nettype wire

// *** test/port_a_c_gpio_mux_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module port_a_c_gpio_mux_tb;
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic [3:0]  avs_byteenable, spi_pin_own, spi_pin_out, spi_pin_oe, spi_pin_in;
  logic [3:0]  own_req, out_req, oe_req;
  logic        die_link_enable, die_link_clock_src, die_link_interrupt_in, len_req, lclk_req;
  logic [5:0]  pa_pin_in, pa_pin_out, pa_pin_oe, pa_ext;
  logic [1:0]  pc_pin_in, pc_pin_out, pc_pin_oe, pc_ext;
  int          failures, check_count;

  // wire level: the driving party wins, else the outside world
  assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & pa_ext);
  assign pc_pin_in = (pc_pin_oe & pc_pin_out) | (~pc_pin_oe & pc_ext);

  pacg_port_mux pacg_port_mux_inst (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .spi_pin_own(spi_pin_own), .spi_pin_out(spi_pin_out), .spi_pin_oe(spi_pin_oe),
    .spi_pin_in(spi_pin_in), .die_link_enable(die_link_enable),
    .die_link_clock_src(die_link_clock_src), .die_link_interrupt_in(die_link_interrupt_in),
    .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe),
    .pc_pin_in(pc_pin_in), .pc_pin_out(pc_pin_out), .pc_pin_oe(pc_pin_oe));

  pacg_periph_model pacg_periph_model_inst (.clk_sys(clk_sys), .reset(reset),
    .spi_own_req(own_req), .spi_out_req(out_req), .spi_oe_req(oe_req),
    .link_en_req(len_req), .link_clk_req(lclk_req), .spi_pin_own(spi_pin_own),
    .spi_pin_out(spi_pin_out), .spi_pin_oe(spi_pin_oe), .die_link_enable(die_link_enable),
    .die_link_clock_src(die_link_clock_src));

  // ****************************************************************
  // bus access tasks
  // ****************************************************************
  // holds the request until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus_xfer(input logic wr, input logic [8:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd_q      = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus_xfer

  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      bus_xfer(1'b0, 9'(i), 8'h00);
      `CHK(rd_q, 32'h00000000)
    end
    $display("reset values done");
  endtask : t_reset

  task automatic t_dir_data();
    bus_xfer(1'b1, 9'h002, 8'hff);
    bus_xfer(1'b1, 9'h000, 8'hff);
    bus_xfer(1'b0, 9'h002, 8'h00);
    `CHK(rd_q, 32'h0000003f)
    bus_xfer(1'b0, 9'h000, 8'h00);
    `CHK(rd_q, 32'h0000003f)
    repeat (2) @(posedge clk_sys);
    `CHK(pa_pin_oe, 6'h3f)
    `CHK(pa_pin_out, 6'h3f)
    $display("direction and data done");
  endtask : t_dir_data

  task automatic t_inputs();
    pa_ext <= 6'h3a;
    bus_xfer(1'b1, 9'h002, 8'h0f);
    bus_xfer(1'b1, 9'h000, 8'h05);
    repeat (4) @(posedge clk_sys);
    `CHK(pa_pin_oe, 6'h0f)
    bus_xfer(1'b0, 9'h000, 8'h00);
    `CHK(rd_q, 32'h00000035)
    $display("input view done");
  endtask : t_inputs

  task automatic t_reserved();
    bus_xfer(1'b1, 9'h001, 8'hff);
    bus_xfer(1'b1, 9'h003, 8'hff);
    bus_xfer(1'b0, 9'h001, 8'h00);
    `CHK(rd_q, 32'h00000000)
    bus_xfer(1'b0, 9'h003, 8'h00);
    `CHK(rd_q, 32'h00000000)
    avs_byteenable <= 4'h0;
    bus_xfer(1'b1, 9'h002, 8'hff);
    avs_byteenable <= 4'h1;
    bus_xfer(1'b0, 9'h002, 8'h00);
    `CHK(rd_q, 32'h0000000f)
    $display("reserved done");
  endtask : t_reserved

  task automatic t_spi();
    bus_xfer(1'b1, 9'h002, 8'h30);
    bus_xfer(1'b1, 9'h000, 8'h20);
    pa_ext  <= 6'h39;
    own_req <= 4'hf;
    out_req <= 4'ha;
    oe_req  <= 4'h6;
    repeat (5) @(posedge clk_sys);
    `CHK(pa_pin_oe, 6'h36)
    `CHK(pa_pin_out, 6'h2a)
    `CHK(spi_pin_in, 4'hb)
    bus_xfer(1'b0, 9'h002, 8'h00);
    `CHK(rd_q, 32'h00000030)
    own_req <= 4'h0;
    repeat (3) @(posedge clk_sys);
    `CHK(pa_pin_oe, 6'h30)
    $display("spi sharing done");
  endtask : t_spi

  task automatic t_portc();
    bus_xfer(1'b1, 9'h004, 8'hff);
    bus_xfer(1'b1, 9'h006, 8'h03);
    bus_xfer(1'b0, 9'h004, 8'h00);
    `CHK(rd_q, 32'h00000003)
    repeat (2) @(posedge clk_sys);
    `CHK(pc_pin_oe, 2'h3)
    `CHK(pc_pin_out, 2'h3)
    pc_ext   <= 2'h2;
    len_req  <= 1'b1;
    lclk_req <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK(pc_pin_oe, 2'h1)
    `CHK(pc_pin_out[0], 1'b0)
    `CHK(die_link_interrupt_in, 1'b1)
    lclk_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(pc_pin_out[0], 1'b1)
    len_req <= 1'b0;
    pc_ext  <= 2'h1;
    bus_xfer(1'b1, 9'h006, 8'h00);
    repeat (4) @(posedge clk_sys);
    `CHK(die_link_interrupt_in, 1'b0)
    bus_xfer(1'b0, 9'h004, 8'h00);
    `CHK(rd_q, 32'h00000001)
    $display("port c done");
  endtask : t_portc

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // cuts a hang short after far more than the tests need
  initial begin
    #20000;
    failures++;
    end_sim();
  end

  // drives everything at time zero, resets, then runs the scenarios
  initial begin
    failures = 0;
    check_count = 0;
    reset <= 1'b1;
    {avs_read, avs_write, len_req, lclk_req} <= 4'h0;
    {avs_address, avs_writedata} <= 43'h0;
    avs_byteenable <= 4'h1;
    {own_req, out_req, oe_req} <= 12'h000;
    pa_ext <= 6'h00;
    pc_ext <= 2'h0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_dir_data();
    t_inputs();
    t_reserved();
    t_spi();
    t_portc();
    end_sim();
  end
endmodule : port_a_c_gpio_mux_tb

`default_nettype wire
